// >>> rtl/dcf_pkg.sv
// constants shared by both ends of the daisy-chain serial front end
package dcf_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam logic [15:0] BIT_CYC_RST = 16'h00D9;
   localparam int RSP_TMO_US = 1000;
   localparam int RSP_TMO_CYC = RSP_TMO_US * 1000 / CLK_NS;
   // ----------------------------------------------------------------
   // protocol bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] LEAD_ADDR = 8'hAA;
   localparam logic [7:0] LEAD_OLD = 8'h80;
   localparam logic [2:0] SET_BASE_HI = 3'h6;
   localparam logic [7:0] SET_BASE = 8'hC0;
   localparam logic [7:0] SET_LO_MSK = 8'h1F;
   localparam logic [7:0] SET_HI_MSK = 8'h7F;
   localparam logic [7:0] RD_TGT = 8'hA3;
   localparam logic [7:0] RD_FB = 8'hA5;
   // ----------------------------------------------------------------
   // serial modes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_DUAL = 2'h0;
   localparam logic [1:0] MODE_CHAIN = 2'h1;
   localparam logic [1:0] MODE_UART = 2'h2;
   // ----------------------------------------------------------------
   // register map (byte offsets) and fields
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_BAUD = 5'h04;
   localparam logic [4:0] REG_STS = 5'h08;
   localparam logic [4:0] REG_MASK = 5'h0C;
   localparam logic [4:0] REG_STATE = 5'h10;
   localparam int CTRL_DEV_LSB = 0;
   localparam int CTRL_MODE_LSB = 8;
   localparam int CTRL_INSER = 10;
   localparam int CTRL_ABAUD = 11;
   localparam logic [31:0] CTRL_RST = 32'h0000000B;
   localparam int STS_CMD = 0;
   localparam int STS_FOREIGN = 1;
   localparam int STS_LOCK = 2;
   localparam int STS_LEGACY = 3;
   localparam int STATE_LOCK = 12;
   localparam int STATE_ERR = 13;
endpackage

// >>> rtl/dcf_link_if.sv
// serial chain wires between the master and the controller
`timescale 1ns/1ps
interface dcf_link_if;
   logic m2s;
   logic s2m;
   logic err;
   modport dev (input m2s, output s2m, output err);
   modport mst (output m2s, input s2m, input err);
endinterface

// >>> rtl/dcf_dev.sv
// controller end: addressed parser, relay modes, uart, register slave
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dcf_dev
   import dcf_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial chain
   dcf_link_if.dev link,
   // host command channel
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   // host passthrough channel
   input wire logic pt_valid,
   input wire logic [7:0] pt_data,
   output logic pt_ready,
   // bytes to host
   output logic hout_valid,
   output logic [7:0] hout_data,
   // motor side
   input wire logic [11:0] fb_val,
   input wire logic err_stop,
   output logic [11:0] target,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);
   typedef enum {R_IDLE, R_MEAS, R_START, R_DATA, R_STOP} dcf_rx_t;
   typedef enum {P_IDLE, P_DEV, P_CMD, P_DATA, P_SKIP} dcf_ps_t;

   logic [31:0] ctrl_r;
   logic [15:0] bit_r;
   logic [3:0] sts_r, mask_r;
   logic [2:0] rx_s_r;
   logic rxf_r, locked_r;
   dcf_rx_t rx_st_r;
   logic [15:0] rx_cnt_r;
   logic [2:0] rx_idx_r;
   logic [7:0] rx_sh_r;
   logic rx_vld_r;
   logic [7:0] rx_byte_r;
   dcf_ps_t ps_r, ps_eff;
   logic ours_r;
   logic [4:0] lo5_r;
   logic [11:0] rsp_val_r;
   logic [1:0] rsp_cnt_r;
   logic tx_busy_r;
   logic [9:0] tx_sh_r;
   logic [3:0] tx_idx_r;
   logic [15:0] tx_cnt_r;
   logic wait_r;
   logic [1:0] mode;
   logic uart, fwd, ld_rsp, ld_pt, ld_ch, tx_ld, rsp_go, pb_vld, acc;
   logic [7:0] pb, rsp_byte, tx_byte;
   logic ev_cmd, ev_for, ev_leg, ev_lock, rsp_start;
   logic [3:0] sts_nxt;

   assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
   assign uart = (mode == MODE_UART);

   // ----------------------------------------------------------------
   // rx pin synchroniser and uart receiver with autobaud
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         rx_s_r <= 3'h7;
         rxf_r <= 1'b1;
      end
      else
      begin
         rx_s_r <= {rx_s_r[1:0], link.m2s};
         if (rx_s_r[1] == rx_s_r[2])
            rxf_r <= rx_s_r[2];
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         rx_st_r <= R_IDLE;
         rx_cnt_r <= 16'h0000;
         rx_idx_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_vld_r <= 1'b0;
         rx_byte_r <= 8'h00;
         locked_r <= 1'b0;
         bit_r <= BIT_CYC_RST;
      end
      else
      begin
         rx_vld_r <= 1'b0;
         if (acc && avs_write && avs_address == REG_BAUD && avs_byteenable[0])
            bit_r <= avs_writedata[15:0];
         case (rx_st_r)
            R_IDLE:
               if (!rxf_r)
               begin
                  // measuring counts this first low cycle too
                  rx_cnt_r <= (ctrl_r[CTRL_ABAUD] && !locked_r) ? 16'h0001 : 16'h0000;
                  rx_st_r <= (ctrl_r[CTRL_ABAUD] && !locked_r) ? R_MEAS : R_START;
               end
            R_MEAS:
               if (rxf_r)
               begin
                  // low span of 0xAA is start bit plus bit 0
                  bit_r <= {1'b0, rx_cnt_r[15:1]};
                  locked_r <= 1'b1;
                  rx_cnt_r <= {2'b00, rx_cnt_r[15:2]};
                  rx_sh_r <= 8'h00;
                  rx_idx_r <= 3'h1;
                  rx_st_r <= R_DATA;
               end
               else if (rx_cnt_r != 16'hFFFF)
                  rx_cnt_r <= rx_cnt_r + 16'h0001;
            R_START:
               if (rx_cnt_r == {1'b0, bit_r[15:1]})
               begin
                  rx_cnt_r <= 16'h0000;
                  rx_idx_r <= 3'h0;
                  rx_st_r <= rxf_r ? R_IDLE : R_DATA;
               end
               else
                  rx_cnt_r <= rx_cnt_r + 16'h0001;
            R_DATA:
               if (rx_cnt_r >= bit_r - 16'h0001)
               begin
                  rx_cnt_r <= 16'h0000;
                  rx_sh_r <= {rxf_r, rx_sh_r[7:1]};
                  rx_idx_r <= rx_idx_r + 3'h1;
                  if (rx_idx_r == 3'h7)
                     rx_st_r <= R_STOP;
               end
               else
                  rx_cnt_r <= rx_cnt_r + 16'h0001;
            R_STOP:
               if (rx_cnt_r >= bit_r - 16'h0001)
               begin
                  rx_vld_r <= rxf_r;
                  rx_byte_r <= rx_sh_r;
                  rx_st_r <= R_IDLE;
               end
               else
                  rx_cnt_r <= rx_cnt_r + 16'h0001;
            default:
               rx_st_r <= R_IDLE;
         endcase
      end

   // ----------------------------------------------------------------
   // byte routing
   // ----------------------------------------------------------------
   always_comb
   begin
      pb_vld = uart ? rx_vld_r : (cmd_valid && cmd_ready && !uart);
      pb = uart ? rx_byte_r : cmd_data;
      fwd = !uart && ctrl_r[CTRL_INSER] && rx_vld_r;
      rsp_byte = (rsp_cnt_r == 2'h2) ? rsp_val_r[7:0] : {4'h0, rsp_val_r[11:8]};
      ld_rsp = uart && rsp_cnt_r != 2'h0 && !tx_busy_r;
      ld_pt = mode == MODE_DUAL && pt_valid && pt_ready;
      ld_ch = mode == MODE_CHAIN && cmd_valid && cmd_ready;
      tx_ld = ld_rsp || ld_pt || ld_ch;
      tx_byte = ld_rsp ? rsp_byte : (ld_pt ? pt_data : cmd_data);
      rsp_go = uart ? ld_rsp : (rsp_cnt_r != 2'h0 && !fwd);
   end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         cmd_ready <= 1'b0;
         pt_ready <= 1'b0;
         hout_valid <= 1'b0;
         hout_data <= 8'h00;
      end
      else
      begin
         // uart mode: host command bytes are taken and dropped
         cmd_ready <= uart || (rsp_cnt_r == 2'h0 && !rsp_start &&
            (mode != MODE_CHAIN || (!tx_busy_r && !tx_ld)));
         pt_ready <= mode == MODE_DUAL && !tx_busy_r && !tx_ld;
         hout_valid <= fwd || rsp_go;
         hout_data <= fwd ? rx_byte_r : rsp_byte;
      end

   // ----------------------------------------------------------------
   // packet parser
   // ----------------------------------------------------------------
   always_comb
   begin
      ps_eff = (ps_r == P_SKIP && pb[7]) ? P_IDLE : ps_r;
      ev_cmd = 1'b0;
      ev_for = 1'b0;
      ev_leg = 1'b0;
      rsp_start = 1'b0;
      if (pb_vld && (ps_eff == P_CMD || (ps_eff == P_IDLE && pb[7] && pb != LEAD_ADDR
         && !(pb == LEAD_OLD && locked_r))))
      begin
         ev_cmd = ps_eff == P_IDLE || ours_r;
         ev_for = ps_eff == P_CMD && !ours_r;
         rsp_start = ev_cmd && ({1'b1, pb[6:0]} == RD_TGT || {1'b1, pb[6:0]} == RD_FB);
      end
      if (pb_vld && ps_eff == P_IDLE && pb == LEAD_OLD && locked_r)
         ev_leg = 1'b1;
   end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         ps_r <= P_IDLE;
         ours_r <= 1'b0;
         lo5_r <= 5'h00;
         target <= 12'h000;
      end
      else if (pb_vld)
         case (ps_eff)
            P_IDLE:
               if (pb == LEAD_ADDR)
                  ps_r <= P_DEV;
               else if (pb == LEAD_OLD && locked_r)
                  ps_r <= P_SKIP;
               else if (pb[7:5] == SET_BASE_HI)
               begin
                  ours_r <= 1'b1;
                  lo5_r <= pb[4:0] & SET_LO_MSK[4:0];
                  ps_r <= P_DATA;
               end
            P_DEV:
               if (pb[7])
                  ps_r <= P_IDLE;
               else
               begin
                  ours_r <= pb[6:0] == ctrl_r[CTRL_DEV_LSB +: 7];
                  ps_r <= P_CMD;
               end
            P_CMD:
               if (pb[7])
                  ps_r <= P_IDLE;
               else if ({1'b1, pb[6:0]} >= SET_BASE && {1'b1, pb[6:0]} <= (SET_BASE | SET_LO_MSK))
               begin
                  lo5_r <= pb[4:0];
                  ps_r <= P_DATA;
               end
               else
                  ps_r <= P_IDLE;
            P_DATA:
            begin
               if (ours_r && !pb[7])
                  target <= {pb[6:0] & SET_HI_MSK[6:0], lo5_r};
               ps_r <= P_IDLE;
            end
            P_SKIP:
               ps_r <= P_SKIP;
            default:
               ps_r <= P_IDLE;
         endcase

   // ----------------------------------------------------------------
   // reply sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         rsp_cnt_r <= 2'h0;
         rsp_val_r <= 12'h000;
      end
      else if (rsp_start)
      begin
         // requests addressed to this device and bare read requests (RD_TGT, RD_FB) from idle start a reply
         rsp_cnt_r <= 2'h2;
         rsp_val_r <= ({1'b1, pb[6:0]} == RD_TGT) ? target : fb_val;
      end
      else if (rsp_go)
         rsp_cnt_r <= rsp_cnt_r - 2'h1;

   // ----------------------------------------------------------------
   // uart transmitter
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         tx_busy_r <= 1'b0;
         tx_sh_r <= 10'h3FF;
         tx_idx_r <= 4'h0;
         tx_cnt_r <= 16'h0000;
         link.s2m <= 1'b1;
      end
      else if (!tx_busy_r)
      begin
         link.s2m <= 1'b1;
         if (tx_ld)
         begin
            tx_busy_r <= 1'b1;
            tx_sh_r <= {1'b1, tx_byte, 1'b0};
            tx_idx_r <= 4'h0;
            tx_cnt_r <= 16'h0000;
         end
      end
      else
      begin
         link.s2m <= tx_sh_r[0];
         if (tx_cnt_r >= bit_r - 16'h0001)
         begin
            tx_cnt_r <= 16'h0000;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_idx_r <= tx_idx_r + 4'h1;
            if (tx_idx_r == 4'h9)
               tx_busy_r <= 1'b0;
         end
         else
            tx_cnt_r <= tx_cnt_r + 16'h0001;
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         link.err <= 1'b0;
      else
         link.err <= err_stop;

   // ----------------------------------------------------------------
   // register slave and interrupt
   // ----------------------------------------------------------------
   assign acc = (avs_read || avs_write) && !wait_r;
   assign ev_lock = rx_st_r == R_MEAS && rxf_r;
   always_comb
   begin
      sts_nxt = sts_r;
      if (acc && avs_read && avs_address == REG_STS)
         sts_nxt = sts_r & ~avs_readdata[3:0];
      sts_nxt[STS_CMD] = sts_nxt[STS_CMD] | ev_cmd;
      sts_nxt[STS_FOREIGN] = sts_nxt[STS_FOREIGN] | ev_for;
      sts_nxt[STS_LOCK] = sts_nxt[STS_LOCK] | ev_lock;
      sts_nxt[STS_LEGACY] = sts_nxt[STS_LEGACY] | ev_leg;
   end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         wait_r <= 1'b1;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         ctrl_r <= CTRL_RST;
         mask_r <= 4'h0;
         sts_r <= 4'h0;
         irq <= 1'b0;
      end
      else
      begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         avs_waitrequest <= !((avs_read || avs_write) && wait_r);
         sts_r <= sts_nxt;
         irq <= |(sts_nxt & mask_r);
         if ((avs_read || avs_write) && wait_r)
            case (avs_address)
               REG_CTRL: avs_readdata <= ctrl_r;
               REG_BAUD: avs_readdata <= {16'h0000, bit_r};
               REG_STS: avs_readdata <= {28'h0000000, sts_r};
               REG_MASK: avs_readdata <= {28'h0000000, mask_r};
               REG_STATE: avs_readdata <= {18'h00000, link.err, locked_r, target};
               default: avs_readdata <= 32'h00000000;
            endcase
         if (acc && avs_write && avs_byteenable[0] && avs_address == REG_MASK)
            mask_r <= avs_writedata[3:0];
         if (acc && avs_write && avs_address == REG_CTRL)
         begin
            if (avs_byteenable[0])
               ctrl_r[7:0] <= {1'b0, avs_writedata[6:0]};
            if (avs_byteenable[1])
               ctrl_r[15:8] <= {4'h0, avs_writedata[11:8]};
         end
      end
endmodule

// >>> rtl/dcf_mst.sv
// master end: drives every slave rx, collects replies one at a time
`timescale 1ns/1ps
module dcf_mst
   import dcf_pkg::*;
#(
   parameter int TMO_CYC = RSP_TMO_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial chain
   dcf_link_if.mst link,
   // bytes to send, with number of reply bytes awaited after each
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic [1:0] tx_reply_n,
   input wire logic lead_req,
   output logic tx_ready,
   // received reply bytes and error monitor
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic err_seen
);
   logic busy_r, lead_pend_r;
   logic [9:0] sh_r;
   logic [3:0] idx_r;
   logic [15:0] cnt_r;
   logic [1:0] want_r, want_nxt_r;
   logic [31:0] tmo_r;
   logic [2:0] s_r, e_r;
   logic rxf_r;
   logic [3:0] ridx_r;
   logic [15:0] rcnt_r;
   logic [8:0] rsh_r;
   logic rbusy_r;
   logic take, last;

   assign take = !busy_r && want_r == 2'h0 && (lead_pend_r || (tx_valid && tx_ready));
   assign last = busy_r && cnt_r == BIT_CYC_RST - 16'h0001 && idx_r == 4'h9;

   // ----------------------------------------------------------------
   // transmitter, one line to all slaves
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         busy_r <= 1'b0;
         lead_pend_r <= 1'b0;
         sh_r <= 10'h3FF;
         idx_r <= 4'h0;
         cnt_r <= 16'h0000;
         want_nxt_r <= 2'h0;
         tx_ready <= 1'b0;
         link.m2s <= 1'b1;
      end
      else
      begin
         tx_ready <= !busy_r && !take && want_r == 2'h0 && !lead_pend_r && !lead_req;
         if (lead_req)
            lead_pend_r <= 1'b1;
         link.m2s <= busy_r ? sh_r[0] : 1'b1;
         if (take)
         begin
            busy_r <= 1'b1;
            lead_pend_r <= 1'b0;
            sh_r <= {1'b1, lead_pend_r ? LEAD_OLD : tx_data, 1'b0};
            want_nxt_r <= lead_pend_r ? 2'h0 : tx_reply_n;
            idx_r <= 4'h0;
            cnt_r <= 16'h0000;
         end
         else if (busy_r)
         begin
            if (cnt_r == BIT_CYC_RST - 16'h0001)
            begin
               cnt_r <= 16'h0000;
               sh_r <= {1'b1, sh_r[9:1]};
               idx_r <= idx_r + 4'h1;
               if (idx_r == 4'h9)
                  busy_r <= 1'b0;
            end
            else
               cnt_r <= cnt_r + 16'h0001;
         end
      end

   // ----------------------------------------------------------------
   // reply wait: one addressed request outstanding at a time
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         want_r <= 2'h0;
         tmo_r <= 32'h00000000;
      end
      else if (last)
      begin
         want_r <= want_nxt_r;
         tmo_r <= 32'h00000000;
      end
      else if (want_r != 2'h0)
      begin
         tmo_r <= tmo_r + 32'h00000001;
         if (rx_valid)
            want_r <= want_r - 2'h1;
         else if (tmo_r >= TMO_CYC)
            want_r <= 2'h0;
      end

   // ----------------------------------------------------------------
   // receiver on the merged slave reply line
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         s_r <= 3'h7;
         e_r <= 3'h0;
         rxf_r <= 1'b1;
         err_seen <= 1'b0;
      end
      else
      begin
         s_r <= {s_r[1:0], link.s2m};
         e_r <= {e_r[1:0], link.err};
         if (s_r[1] == s_r[2])
            rxf_r <= s_r[2];
         if (e_r[1] == e_r[2])
            err_seen <= e_r[2];
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         rbusy_r <= 1'b0;
         ridx_r <= 4'h0;
         rcnt_r <= 16'h0000;
         rsh_r <= 9'h000;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rbusy_r)
         begin
            rcnt_r <= {1'b0, BIT_CYC_RST[15:1]};
            ridx_r <= 4'h0;
            rbusy_r <= !rxf_r;
         end
         else if (rcnt_r == BIT_CYC_RST - 16'h0001)
         begin
            rcnt_r <= 16'h0000;
            rsh_r <= {rxf_r, rsh_r[8:1]};
            ridx_r <= ridx_r + 4'h1;
            // tenth sample is the stop bit, data sits in rsh_r[8:1]
            if (ridx_r == 4'h9)
            begin
               rbusy_r <= 1'b0;
               rx_valid <= rxf_r;
               rx_data <= rsh_r[8:1];
            end
         end
         else
            rcnt_r <= rcnt_r + 16'h0001;
      end
endmodule

// >>> dv/dcf_link_sva.sv
// checker on the serial chain wires
`timescale 1ns/1ps
module dcf_link_sva
   import dcf_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // chain wires
   input wire logic m2s,
   input wire logic s2m,
   input wire logic err,
   // error cause and monitor
   input wire logic err_stop,
   input wire logic err_seen
);
   logic s_q, m_q;
   logic [15:0] s_run, m_run;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ---
   // run length of each s2m and m2s level
   // ---
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         s_q <= 1'b1;
         m_q <= 1'b1;
         s_run <= 16'hFFFF;
         m_run <= 16'hFFFF;
      end
      else
      begin
         s_q <= s2m;
         m_q <= m2s;
         s_run <= (s2m != s_q) ? 16'h0001 : s_run + {15'h0000, s_run != 16'hFFFF};
         m_run <= (m2s != m_q) ? 16'h0001 : m_run + {15'h0000, m_run != 16'hFFFF};
      end
   property p_idle;
      $fell(rst) |-> s2m && m2s && !err;
   endproperty
   a_idle: assert property (p_idle) else $error("lines not idle after reset");
   property p_s_bit;
      (s2m != s_q) |-> s_run >= BIT_CYC_RST;
   endproperty
   a_s_bit: assert property (p_s_bit) else $error("s2m level shorter than a bit");
   property p_m_bit;
      (m2s != m_q) |-> m_run >= BIT_CYC_RST;
   endproperty
   a_m_bit: assert property (p_m_bit) else $error("m2s level shorter than a bit");
   property p_s_low;
      (!s2m && !s_q) |-> s_run < 9 * BIT_CYC_RST;
   endproperty
   a_s_low: assert property (p_s_low) else $error("s2m low past a frame");
   property p_m_low;
      (!m2s && !m_q) |-> m_run < 9 * BIT_CYC_RST;
   endproperty
   a_m_low: assert property (p_m_low) else $error("m2s low past a frame");
   property p_err_on;
      $rose(err_stop) |-> ##[0:2] err;
   endproperty
   a_err_on: assert property (p_err_on) else $error("error line not raised");
   property p_err_off;
      $fell(err_stop) |-> ##[0:2] !err;
   endproperty
   a_err_off: assert property (p_err_off) else $error("error line not dropped");
   property p_err_mon;
      $rose(err) |-> ##[1:4] err_seen;
   endproperty
   a_err_mon: assert property (p_err_mon) else $error("error line not seen");
endmodule

// >>> dv/test_daisy_chain_serial_front_end.sv
// bench: master and controller joined across the chain wires
`timescale 1ns/1ps
module test_daisy_chain_serial_front_end
   import dcf_pkg::*;
;
   logic mclk, rst, cmd_valid, cmd_ready, hout_valid, err_stop, irq;
   logic avs_read, avs_write, avs_waitrequest, tx_valid, tx_ready, rx_valid, err_seen;
   logic [7:0] cmd_data, hout_data, tx_data, rx_data;
   logic [11:0] fb_val, target;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] tx_reply_n;
   logic pt_valid, pt_ready, lead_req;
   logic [7:0] pt_data;
   logic [7:0] rq[$];
   logic [7:0] hq[$];
   int error_cnt, check_count, cyc;
   dcf_link_if link();
   dcf_dev u_dcf_dev (.mclk, .rst, .link(link.dev), .cmd_valid, .cmd_data, .cmd_ready,
      .pt_valid, .pt_data, .pt_ready, .hout_valid, .hout_data, .fb_val,
      .err_stop, .target, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq);
   dcf_mst u_dcf_mst (.mclk, .rst, .link(link.mst), .tx_valid, .tx_data, .tx_reply_n,
      .lead_req, .tx_ready, .rx_valid, .rx_data, .err_seen);
   dcf_link_sva u_dcf_link_sva (.mclk, .rst, .m2s(link.m2s), .s2m(link.s2m), .err(link.err),
      .err_stop, .err_seen);
   // ---
   // clock, timeout and byte collectors
   // ---
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (rx_valid === 1'b1)
         rq.push_back(rx_data);
      if (hout_valid === 1'b1)
         hq.push_back(hout_data);
      if (cyc == 80000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("errors=%0d checks=%0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic hc(input logic p, input logic [7:0] b);
      @(posedge mclk);
      cmd_valid <= !p;
      pt_valid <= p;
      cmd_data <= b;
      pt_data <= b;
      do
         @(posedge mclk);
      while ((p ? pt_ready : cmd_ready) !== 1'b1);
      cmd_valid <= 1'b0;
      pt_valid <= 1'b0;
   endtask
   task automatic snd(input logic [7:0] b, input logic [1:0] n);
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data <= b;
      tx_reply_n <= n;
      do
         @(posedge mclk);
      while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
      do
         @(posedge mclk);
      while (tx_ready !== 1'b1);
   endtask
   // ---
   // main sequence
   // ---
   initial
   begin
      {cmd_valid, avs_read, avs_write, tx_valid, err_stop, cmd_data, tx_data, tx_reply_n} = '0;
      {avs_address, avs_writedata, pt_valid, pt_data, lead_req} = '0;
      fb_val = 12'h5A7;
      rst = 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      bus(0, REG_CTRL, 0);
      chk(q, CTRL_RST);
      bus(0, 5'h1C, 0);
      chk(q, 32'h0);
      bus(1, REG_MASK, 32'hF);
      hc(0, 8'hCD);
      hc(0, 8'h5E);
      hc(0, LEAD_ADDR);
      hc(0, 8'h0B);
      hc(0, RD_TGT & 8'h7F);
      wait (hq.size() >= 2);
      chk({hq[1], hq[0]}, 12'hBCD);
      chk(target, 12'hBCD);
      chk(irq, 1);
      bus(0, REG_STS, 0);
      chk(q, 32'h1);
      hq.delete();
      snd(8'h5A, 0);
      bus(1, REG_CTRL, 32'h40B);
      chk(irq, 0);
      snd(8'h3C, 0);
      wait (hq.size() >= 1);
      chk(hq.size(), 1);
      chk(hq[0], 8'h3C);
      bus(1, REG_MASK, 0);
      bus(1, REG_CTRL, 32'hA0B);
      hq.delete();
      err_stop <= 1'b1;
      snd(LEAD_ADDR, 0);
      snd(8'h0B, 0);
      snd(RD_FB & 8'h7F, 2);
      chk({rq[1], rq[0]}, 12'h5A7);
      bus(0, REG_STS, 0);
      chk(q, 32'h5);
      snd(LEAD_ADDR, 0);
      snd(8'h05, 0);
      snd(8'h23, 0);
      snd(LEAD_OLD, 0);
      lead_req <= 1'b1;
      @(posedge mclk);
      lead_req <= 1'b0;
      snd(8'h0B, 0);
      snd(8'h23, 0);
      snd(RD_TGT, 2);
      chk(rq.size(), 4);
      chk({rq[3], rq[2]}, 12'hBCD);
      chk(hq.size(), 4);
      chk(irq, 0);
      bus(0, REG_STS, 0);
      chk(q, 32'hB);
      bus(0, REG_STATE, 0);
      chk(q, 32'h3BCD);
      bus(1, REG_CTRL, 32'h10B);
      hc(0, 8'h55);
      bus(1, REG_CTRL, 32'h00B);
      hc(1, 8'h66);
      wait (rq.size() >= 6);
      chk({rq[5], rq[4]}, 16'h6655);
      err_stop <= 1'b0;
      repeat (4) @(posedge mclk);
      finish_test();
   end
endmodule
